// ### logic/flash_host.sv
// Notes on behaviour
// - host may start completion polling immediately after programming begins
// - whole array erase by a six write software sequence, optional
// - host locks a region with seven program writes, six to set addresses and the last to the region
// - host exits software id mode after lock queries
// - each further byte load starts within 150 us of previous strobe rise
module flash_host
  import flash_host_pkg::*;
#(
  parameter int         POWERON_CYCLES = POWERON_CYC,
  parameter int         WINDOW_CYCLES  = BLC_CYC,
  parameter int         WRITE_CYCLES   = WC_CYC,
  parameter seq_entry_t SEQ_TABLE [SEQ_N] = SEQ_DEFAULT
) (
  input  wire logic        mclk_in,
  input  wire logic        reset_in,
  input  wire logic        supply_good_in,
  input  wire logic        cmd_valid_in,
  input  wire logic [2:0]  cmd_in,
  input  wire logic [18:0] cmd_addr_in,
  input  wire logic [7:0]  cmd_data_in,
  output logic             cmd_ready_out,
  output logic             rsp_valid_out,
  output logic [7:0]       rsp_data_out,
  output logic [15:0]      rsp_id_out,
  output logic [1:0]       rsp_lock_out,
  output logic             rsp_timeout_out,
  output logic             busy_out,
  output logic [18:0]      flash_addr_out,
  output logic             flash_ce_n_out,
  output logic             flash_oe_n_out,
  output logic             flash_we_n_out,
  output logic [7:0]       flash_dq_out,
  output logic             flash_dq_oe_out,
  input  wire logic [7:0]  flash_dq_in
);

  // next load must fall before the window closes, setup included
  localparam logic [19:0] WIN_LIMIT = 20'(WINDOW_CYCLES - AS_CYC - 2);

  typedef struct packed {
    state_t      st;
    phase_t      ph;
    logic [7:0]  tcnt;
    logic [19:0] bigcnt;
    logic [19:0] win;
    logic [4:0]  idx;
    logic [1:0]  qidx;
    cmd_t        cmd;
    logic [18:0] addr;
    logic [18:0] last_addr;
    logic [7:0]  last_data;
    logic        wr;
    logic [7:0]  rdata;
    logic        prev_tog;
    logic        tog_valid;
    logic [7:0]  lo_raw;
    logic [7:0]  hi_raw;
    logic [18:0] pin_addr;
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic [7:0]  dq_o;
    logic        dq_oe;
    logic        ready;
    logic        rsp_valid;
    logic [7:0]  rsp_data;
    logic [15:0] rsp_id;
    logic [1:0]  rsp_lock;
    logic        rsp_timeout;
    logic        busy;
  } core_t;

  core_t       r;
  core_t       n;
  logic [8:0]  sync_q;
  logic [7:0]  dq_sync;
  logic        supply_ok;
  logic        acc_done;
  logic        accept;
  logic        poll_ok;
  logic        tog_ok;

  // =========================================================================
  // pin synchronisers
  flash_sync #(
    .WIDTH (9)
  ) u_sync (
    .mclk_in  (mclk_in),
    .reset_in (reset_in),
    .d_in     ({supply_good_in, flash_dq_in}),
    .q_out    (sync_q)
  );

  assign dq_sync   = sync_q[7:0];
  assign supply_ok = sync_q[8];

  function automatic core_t start_acc(core_t s, logic [18:0] a, logic [7:0] d, logic wr);
    core_t t;
    t          = s;
    t.ph       = PH_SETUP;
    t.tcnt     = 8'(AS_CYC);
    t.pin_addr = a;
    t.dq_o     = d;
    t.wr       = wr;
    t.ce_n     = 1'b0;
    t.oe_n     = 1'b1;
    t.dq_oe    = wr;
    return t;
  endfunction : start_acc

  function automatic logic [18:0] seq_addr(logic [4:0] i, logic [18:0] user_addr);
    // last lock write targets the region that the caller names
    return (i == SEQ_LOCK_LAST) ? user_addr : SEQ_TABLE[i].addr;
  endfunction : seq_addr

  function automatic logic [18:0] q_addr(logic [1:0] q);
    case (q)
      2'h0:    return ID_MFR_ADDR;
      2'h1:    return ID_DEV_ADDR;
      2'h2:    return LOCK_LO_ADDR;
      default: return LOCK_HI_ADDR;
    endcase
  endfunction : q_addr

  // =========================================================================
  // next state
  always_comb begin
    n             = r;
    acc_done      = 1'b0;
    n.rsp_valid   = 1'b0;
    n.rsp_timeout = 1'b0;
    accept        = cmd_valid_in && r.ready &&
                    (r.st == ST_IDLE || cmd_t'(cmd_in) == CMD_LOAD);
    poll_ok       = (r.cmd == CMD_ERASE) || (r.rdata[POLL_BIT] == r.last_data[POLL_BIT]);
    tog_ok        = r.tog_valid && (r.rdata[TOGGLE_BIT] == r.prev_tog);
    if (r.win != 20'hFFFFF) begin
      n.win = r.win + 20'h00001;
    end
    if (r.ph != PH_IDLE && r.tcnt != 8'h01) begin
      n.tcnt = r.tcnt - 8'h01;
    end else begin
      case (r.ph)
        PH_SETUP: begin
          n.ph   = PH_STROBE;
          n.tcnt = r.wr ? 8'(WP_CYC) : 8'(ACC_CYC);
          n.we_n = !r.wr;
          n.oe_n = r.wr;
        end
        PH_STROBE: begin
          if (r.wr) begin
            n.we_n = 1'b1;
            n.ph   = PH_HOLD;
            n.tcnt = 8'(DH_CYC);
            n.win  = '0;
          end else begin
            n.rdata = dq_sync;
            n.oe_n  = 1'b1;
            n.ce_n  = 1'b1;
            n.ph    = PH_GAP;
            n.tcnt  = 8'(WPH_CYC);
          end
        end
        PH_HOLD: begin
          n.ce_n  = 1'b1;
          n.dq_oe = 1'b0;
          n.ph    = PH_GAP;
          n.tcnt  = 8'(WPH_CYC);
        end
        PH_GAP: begin
          n.ph     = PH_IDLE;
          acc_done = 1'b1;
        end
        default: ;
      endcase
    end

    case (r.st)
      ST_WAIT_SUPPLY: begin
        n.bigcnt = '0;
        if (supply_ok) begin
          n.st = ST_POWERUP;
        end
      end
      ST_POWERUP: begin
        n.bigcnt = r.bigcnt + 20'h00001;
        if (!supply_ok) begin
          n.st = ST_WAIT_SUPPLY;
        end else if (r.bigcnt >= 20'(POWERON_CYCLES - 1)) begin
          n.st = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (!supply_ok) begin
          n.st = ST_WAIT_SUPPLY;
        end else if (accept) begin
          n.cmd  = cmd_t'(cmd_in);
          n.addr = cmd_addr_in;
          n.win  = '0;
          case (cmd_t'(cmd_in))
            CMD_READ: begin
              n.st = ST_READ;
              n    = start_acc(n, cmd_addr_in, 8'h00, 1'b0);
            end
            CMD_LOAD: begin
              n.st        = ST_LOADWAIT;
              n.last_addr = cmd_addr_in;
              n.last_data = cmd_data_in;
              n           = start_acc(n, cmd_addr_in, cmd_data_in, 1'b1);
            end
            CMD_ERASE: begin
              n.st  = ST_SEQ;
              n.idx = SEQ_ERASE_BASE;
              n     = start_acc(n, SEQ_TABLE[SEQ_ERASE_BASE].addr,
                                SEQ_TABLE[SEQ_ERASE_BASE].data, 1'b1);
            end
            CMD_LOCK: begin
              n.st  = ST_SEQ;
              n.idx = SEQ_LOCK_BASE;
              n     = start_acc(n, SEQ_TABLE[SEQ_LOCK_BASE].addr,
                                SEQ_TABLE[SEQ_LOCK_BASE].data, 1'b1);
            end
            default: begin
              n.st  = ST_SEQ;
              n.idx = SEQ_IDIN_BASE;
              n     = start_acc(n, SEQ_TABLE[SEQ_IDIN_BASE].addr,
                                SEQ_TABLE[SEQ_IDIN_BASE].data, 1'b1);
            end
          endcase
        end
      end
      ST_READ: begin
        if (acc_done) begin
          n.st        = ST_IDLE;
          n.rsp_valid = 1'b1;
          n.rsp_data  = r.rdata;
        end
      end
      ST_SEQ: begin
        if (acc_done) begin
          if (r.idx == SEQ_ERASE_LAST) begin
            n.st        = ST_POLL;
            n.bigcnt    = '0;
            n.tog_valid = 1'b0;
            n.last_addr = ERASE_POLL_ADDR;
            n           = start_acc(n, ERASE_POLL_ADDR, 8'h00, 1'b0);
          end else if (r.idx == SEQ_LOCK_LAST) begin
            n.st        = ST_LOADWAIT;
            n.last_addr = r.addr;
            n.last_data = SEQ_TABLE[SEQ_LOCK_LAST].data;
          end else if (r.idx == SEQ_IDIN_LAST) begin
            n.st   = ST_QREAD;
            n.qidx = 2'h0;
            n      = start_acc(n, q_addr(2'h0), 8'h00, 1'b0);
          end else if (r.idx == SEQ_IDOUT_LAST) begin
            n.st          = ST_IDLE;
            n.rsp_valid   = 1'b1;
            n.rsp_data    = r.lo_raw;
            n.rsp_lock[0] = (r.lo_raw == LOCKED_CODE);
            n.rsp_lock[1] = (r.hi_raw == LOCKED_CODE);
          end else begin
            n.idx = r.idx + 5'h01;
            n     = start_acc(n, seq_addr(r.idx + 5'h01, r.addr),
                              SEQ_TABLE[r.idx + 5'h01].data, 1'b1);
          end
        end
      end
      ST_QREAD: begin
        if (acc_done) begin
          case (r.qidx)
            2'h0:    n.rsp_id[15:8] = r.rdata;
            2'h1:    n.rsp_id[7:0]  = r.rdata;
            2'h2:    n.lo_raw       = r.rdata;
            default: n.hi_raw       = r.rdata;
          endcase
          if (r.qidx == 2'h3) begin
            n.st  = ST_SEQ;
            n.idx = SEQ_IDOUT_BASE;
            n     = start_acc(n, SEQ_TABLE[SEQ_IDOUT_BASE].addr,
                              SEQ_TABLE[SEQ_IDOUT_BASE].data, 1'b1);
          end else begin
            n.qidx = r.qidx + 2'h1;
            n      = start_acc(n, q_addr(r.qidx + 2'h1), 8'h00, 1'b0);
          end
        end
      end
      ST_LOADWAIT: begin
        if (r.ph == PH_IDLE) begin
          if (accept) begin
            n.last_addr = cmd_addr_in;
            n.last_data = cmd_data_in;
            n           = start_acc(n, cmd_addr_in, cmd_data_in, 1'b1);
          end else if (r.win >= WIN_LIMIT) begin
            // the device has closed the load period; poll at once
            n.st        = ST_POLL;
            n.bigcnt    = '0;
            n.tog_valid = 1'b0;
            n           = start_acc(n, r.last_addr, 8'h00, 1'b0);
          end
        end
      end
      ST_POLL: begin
        if (r.bigcnt != 20'hFFFFF) begin
          n.bigcnt = r.bigcnt + 20'h00001;
        end
        if (acc_done) begin
          if (poll_ok && tog_ok) begin
            n.st        = ST_IDLE;
            n.rsp_valid = 1'b1;
            n.rsp_data  = r.rdata;
          end else if (r.bigcnt >= 20'(WRITE_CYCLES)) begin
            // locked region or stuck device: give up after one write cycle time
            n.st          = ST_IDLE;
            n.rsp_valid   = 1'b1;
            n.rsp_timeout = 1'b1;
            n.rsp_data    = r.rdata;
          end else begin
            n.prev_tog  = r.rdata[TOGGLE_BIT];
            n.tog_valid = 1'b1;
            n           = start_acc(n, r.last_addr, 8'h00, 1'b0);
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    n.ready = (n.ph == PH_IDLE) && supply_ok &&
              ((n.st == ST_IDLE) || (n.st == ST_LOADWAIT && n.win < WIN_LIMIT));
    n.busy  = (n.st != ST_IDLE);
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      r       <= '0;
      r.ce_n  <= 1'b1;
      r.oe_n  <= 1'b1;
      r.we_n  <= 1'b1;
      r.busy  <= 1'b1;
      r.win   <= 20'hFFFFF;
    end else begin
      r <= n;
    end
  end

  assign cmd_ready_out   = r.ready;
  assign rsp_valid_out   = r.rsp_valid;
  assign rsp_data_out    = r.rsp_data;
  assign rsp_id_out      = r.rsp_id;
  assign rsp_lock_out    = r.rsp_lock;
  assign rsp_timeout_out = r.rsp_timeout;
  assign busy_out        = r.busy;
  assign flash_addr_out  = r.pin_addr;
  assign flash_ce_n_out  = r.ce_n;
  assign flash_oe_n_out  = r.oe_n;
  assign flash_we_n_out  = r.we_n;
  assign flash_dq_out    = r.dq_o;
  assign flash_dq_oe_out = r.dq_oe;

  // =========================================================================
  // checks
  logic [19:0] up_cnt;
  logic        up_seen;
  logic [3:0]  wcount;
  logic [7:0]  wlow;

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      up_cnt  <= '0;
      up_seen <= 1'b0;
      wcount  <= '0;
      wlow    <= '0;
    end else begin
      // length of the current strobe low run, saturating
      wlow    <= flash_we_n_out ? 8'h00 : (wlow == 8'hFF) ? wlow : wlow + 8'h01;
      up_cnt  <= !supply_ok ? 20'h00000 : (up_cnt == 20'hFFFFF) ? up_cnt : up_cnt + 20'h00001;
      up_seen <= up_seen || (up_cnt >= 20'(POWERON_CYCLES - 1));
      // one count per write strobe launched since the command was taken
      wcount  <= accept ? 4'h0 :
                 (r.wr && r.ph == PH_SETUP && n.ph == PH_STROBE) ? wcount + 4'h1 : wcount;
    end
  end

  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);

  property p_write_gating;
    !flash_we_n_out |-> flash_oe_n_out && !flash_ce_n_out;
  endproperty
  a_write_gating: assert property (p_write_gating) else $error("strobe low with bad gate");

  property p_strobe_width;
    $rose(flash_we_n_out) |-> wlow >= 8'(WP_CYC);
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("write pulse too short");

  property p_powerup_wait;
    $fell(flash_we_n_out) |-> up_seen;
  endproperty
  a_powerup_wait: assert property (p_powerup_wait) else $error("write before power-on delay");

  property p_supply_drop;
    (r.st == ST_IDLE && !supply_ok) |=> (r.st == ST_WAIT_SUPPLY) && !cmd_ready_out;
  endproperty
  a_supply_drop: assert property (p_supply_drop) else $error("idle ignored supply loss");

  property p_load_window;
    ($fell(flash_we_n_out) && r.st == ST_LOADWAIT) |-> (r.win <= 20'(WINDOW_CYCLES));
  endproperty
  a_load_window: assert property (p_load_window) else $error("byte load window exceeded");

  property p_poll_start;
    (r.st == ST_LOADWAIT && n.st == ST_POLL) |-> ##[1:4] $fell(flash_oe_n_out);
  endproperty
  a_poll_start: assert property (p_poll_start) else $error("poll read not started");

  property p_poll_match;
    (rsp_valid_out && !rsp_timeout_out && r.cmd inside {CMD_LOAD, CMD_LOCK})
      |-> rsp_data_out[POLL_BIT] == r.last_data[POLL_BIT] && rsp_data_out[TOGGLE_BIT] == r.prev_tog;
  endproperty
  a_poll_match: assert property (p_poll_match) else $error("completion reported early");

  property p_erase_first;
    (accept && cmd_t'(cmd_in) == CMD_ERASE && r.st == ST_IDLE)
      |-> ##[1:20] ($fell(flash_we_n_out) && flash_addr_out == SEQ_TABLE[0].addr);
  endproperty
  a_erase_first: assert property (p_erase_first) else $error("erase sequence not issued");

  property p_lock_count;
    (r.st == ST_SEQ && n.st == ST_LOADWAIT) |-> wcount == 4'h7;
  endproperty
  a_lock_count: assert property (p_lock_count) else $error("lock needs seven writes");

  property p_query_exit;
    ($rose(flash_oe_n_out) && r.st == ST_QREAD && flash_addr_out == LOCK_HI_ADDR)
      |-> ##[1:100] ($fell(flash_we_n_out) && flash_addr_out == SEQ_TABLE[SEQ_IDOUT_BASE].addr);
  endproperty
  a_query_exit: assert property (p_query_exit) else $error("id mode not exited");

  property p_lock_decode;
    (rsp_valid_out && r.cmd == CMD_QUERY)
      |-> rsp_lock_out == {r.hi_raw == LOCKED_CODE, r.lo_raw == LOCKED_CODE};
  endproperty
  a_lock_decode: assert property (p_lock_decode) else $error("lock state decoded wrong");

  c_read:    cover property (rsp_valid_out && r.cmd == CMD_READ);
  c_program: cover property (rsp_valid_out && !rsp_timeout_out && r.cmd == CMD_LOAD);
  c_erase:   cover property (rsp_valid_out && r.cmd == CMD_ERASE);
  c_query:   cover property (rsp_valid_out && r.cmd == CMD_QUERY && rsp_lock_out != 2'h0);
  c_timeout: cover property (rsp_valid_out && rsp_timeout_out);

endmodule : flash_host

// ### logic/flash_host_pkg.sv
package flash_host_pkg;

  // ==========================================================================
  // clock and pin timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_AS_NS       = 10;
  localparam int T_WP_NS       = 90;
  localparam int T_DH_NS       = 10;
  localparam int T_WPH_NS      = 100;
  localparam int T_ACC_NS      = 120;
  localparam int T_BLC_US      = 150;
  localparam int T_WC_MS       = 10;
  localparam int T_POWERON_MS  = 5;
  localparam int SYNC_STAGES   = 2;

  // least times round up, longest times round down
  localparam int AS_CYC      = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC      = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DH_CYC      = (T_DH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC     = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ACC_CYC     = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES + 1;
  localparam int BLC_CYC     = (T_BLC_US * 1000) / CLK_PERIOD_NS;
  localparam int WC_CYC      = (T_WC_MS * 1000000) / CLK_PERIOD_NS;
  localparam int POWERON_CYC = (T_POWERON_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ==========================================================================
  // array geometry and special locations
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam logic [18:0] ID_MFR_ADDR       = 19'h00000;
  localparam logic [18:0] ID_DEV_ADDR       = 19'h00001;
  localparam logic [18:0] LOCK_LO_ADDR      = 19'h00002;
  localparam logic [19:0] LOCK_HI_ADDR_FULL = 20'hFFFF2;
  // only A0..A18 exist, the top printed bit falls off the pins
  localparam logic [18:0] LOCK_HI_ADDR      = LOCK_HI_ADDR_FULL[18:0];
  localparam logic [18:0] ERASE_POLL_ADDR   = 19'h00000;
  localparam logic [7:0]  LOCKED_CODE       = 8'hFF;
  localparam logic [7:0]  UNLOCKED_CODE     = 8'hFE;
  localparam int          POLL_BIT          = 7;
  localparam int          TOGGLE_BIT        = 6;

  // ==========================================================================
  // command sequence table layout
  typedef struct packed {
    logic [18:0] addr;
    logic [7:0]  data;
  } seq_entry_t;

  localparam int SEQ_N = 19;
  localparam logic [4:0] SEQ_ERASE_BASE = 5'h00;
  localparam logic [4:0] SEQ_ERASE_LAST = 5'h05;
  localparam logic [4:0] SEQ_LOCK_BASE  = 5'h06;
  localparam logic [4:0] SEQ_LOCK_LAST  = 5'h0C;
  localparam logic [4:0] SEQ_IDIN_BASE  = 5'h0D;
  localparam logic [4:0] SEQ_IDIN_LAST  = 5'h0F;
  localparam logic [4:0] SEQ_IDOUT_BASE = 5'h10;
  localparam logic [4:0] SEQ_IDOUT_LAST = 5'h12;

  // plain defaults; the real codes are a top-level parameter
  localparam seq_entry_t SEQ_DEFAULT [SEQ_N] = '{
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'h80},
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'h10},
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'h80},
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'h40},
    '{19'h00000, 8'h00},
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'h90},
    '{19'h05555, 8'hAA}, '{19'h02AAA, 8'h55}, '{19'h05555, 8'hF0}
  };

  // ==========================================================================
  // commands and states
  typedef enum logic [2:0] {
    CMD_READ,
    CMD_LOAD,
    CMD_ERASE,
    CMD_LOCK,
    CMD_QUERY
  } cmd_t;

  typedef enum logic [2:0] {
    ST_WAIT_SUPPLY,
    ST_POWERUP,
    ST_IDLE,
    ST_READ,
    ST_SEQ,
    ST_QREAD,
    ST_LOADWAIT,
    ST_POLL
  } state_t;

  typedef enum logic [2:0] {
    PH_IDLE,
    PH_SETUP,
    PH_STROBE,
    PH_HOLD,
    PH_GAP
  } phase_t;

endpackage : flash_host_pkg

// ### logic/flash_sync.sv
module flash_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             mclk_in,
  input  wire logic             reset_in,
  input  wire logic [WIDTH-1:0] d_in,
  output logic      [WIDTH-1:0] q_out
);

  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t r;
  sync_t n;

  always_comb begin
    n    = r;
    n.s1 = d_in;
    n.s2 = r.s1;
  end

  always_ff @(posedge mclk_in) begin
    if (reset_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  assign q_out = r.s2;

endmodule : flash_sync

// ### testbench/flash_dev_model.sv
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int         PON      = 40,
  parameter int         WIN      = 100,
  parameter int         TPROG    = 300,
  parameter logic [7:0] MFR_CODE = 8'hA5, // arbitrary
  parameter logic [7:0] DEV_CODE = 8'h3C  // arbitrary
) (
  input  wire logic        mclk_in,
  input  wire logic        supply_in,
  input  wire logic        ce_n_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [7:0]  dq_in,
  output logic      [7:0]  dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // array, load buffer and status
  logic [7:0] mem [int];
  logic [7:0] ld [int];
  int         pon = PON, win = 0, tmr = 0, lowc = 0, k, ce = 0, cl = 0, ci = 0, co = 0;
  logic       lk_lo = 1'b0, lk_hi = 1'b0, idm = 1'b0, ers = 1'b0, tog = 1'b0;
  logic       wp = 1'b1, rp = 1'b0;
  logic [7:0] last = 8'h00, q = 8'h00;
  initial dq_out = 8'h00;

  function automatic int step(int c, int b, logic [18:0] a, logic [7:0] d);
    seq_entry_t e = SEQ_DEFAULT[b + c];
    if ((e.addr == a || (b == 6 && c == 6)) && e.data == d) return c + 1;
    return (SEQ_DEFAULT[b].addr == a && SEQ_DEFAULT[b].data == d) ? 1 : 0;
  endfunction : step

  function automatic logic [7:0] rd(logic [18:0] a);
    if (idm && a == ID_MFR_ADDR) return MFR_CODE;
    if (idm && a == ID_DEV_ADDR) return DEV_CODE;
    if (idm && a == LOCK_LO_ADDR) return lk_lo ? 8'hFF : 8'hFE;
    if (idm && a == LOCK_HI_ADDR) return lk_hi ? 8'hFF : 8'hFE;
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction : rd

  task wr(input logic [18:0] a, input logic [7:0] d);
    ce = step(ce, 0, a, d);
    cl = step(cl, 6, a, d);
    ci = step(ci, 13, a, d);
    co = step(co, 16, a, d);
    if (ce == 6) begin
      ce = 0;
      if (!(lk_lo || lk_hi)) begin
        mem.delete();
        ers = 1'b1;
        tmr = TPROG;
      end
    end else if (cl == 7) begin
      cl = 0;
      if (a < 19'h04000) lk_lo = 1'b1;
      else if (a >= 19'h7C000) lk_hi = 1'b1;
    end else if (ci == 3) begin
      ci = 0;
      idm = 1'b1;
    end else if (co == 3) begin
      co = 0;
      idm = 1'b0;
    end else if ((ce | cl | ci | co) == 0) begin
      ld[a] = d;
      last = d;
      win = WIN;
    end
  endtask : wr

  // ====================
  // pins and timers; the released bus shows a changing pattern, not the last byte
  always @(posedge mclk_in) begin
    pon = !supply_in ? PON : (pon > 0 ? pon - 1 : 0);
    if (!we_n_in && !ce_n_in) lowc++;
    else begin
      if (!wp && lowc >= 2 && oe_n_in && supply_in && pon == 0) wr(addr_in, dq_in);
      lowc = 0;
    end
    wp = we_n_in;
    if (win > 0) begin
      win--;
      if (win == 0 && ld.size() != 0) begin
        void'(ld.first(k));
        if (!((k < 'h4000 && lk_lo) || (k >= 'h7C000 && lk_hi))) begin
          for (int i = 0; i < 512; i++) mem[{k[18:9], i[8:0]}] = 8'hFF;
          foreach (ld[j]) mem[j] = ld[j];
          tmr = TPROG;
          ers = 1'b0;
        end
        ld.delete();
      end
    end else if (tmr > 0) tmr--;
    if (!ce_n_in && !oe_n_in) begin
      if (!rp && tmr > 0) tog = ~tog;
      q = rd(addr_in);
      if (tmr > 0) begin
        q[6] = tog;
        if (!ers) q[7] = ~last[7];
      end
    end else q = ~dq_out;
    // non-blocking, so the host's first sync stage never races this edge
    dq_out <= q;
    rp = !ce_n_in && !oe_n_in;
  end
endmodule : flash_dev_model

// ### testbench/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_host_pkg::*;
  localparam logic [7:0] MFR_CODE = 8'hA5; // arbitrary
  localparam logic [7:0] DEV_CODE = 8'h3C; // arbitrary
  logic        mclk_in = 1'b0, reset_in = 1'b1, supply_good_in = 1'b0, cmd_valid_in = 1'b0;
  logic [2:0]  cmd_in = 3'h0;
  logic [18:0] cmd_addr_in = 19'h00000, flash_addr_out, a, b;
  logic [7:0]  cmd_data_in = 8'h00, rsp_data_out, flash_dq_out, dev_dq, d1, d2;
  logic        cmd_ready_out, rsp_valid_out, rsp_timeout_out, busy_out, flash_dq_oe_out;
  logic        flash_ce_n_out, flash_oe_n_out, flash_we_n_out;
  logic [15:0] rsp_id_out;
  logic [1:0]  rsp_lock_out;
  logic [31:0] seed = 32'hFACD664F, r;
  wire  [7:0]  flash_dq_in = flash_dq_oe_out ? flash_dq_out : dev_dq;
  int          miscompares = 0, n_checks = 0;

  always #5 mclk_in = ~mclk_in;

  flash_host #(.POWERON_CYCLES(50), .WINDOW_CYCLES(200), .WRITE_CYCLES(2000)) uut (
    .mclk_in, .reset_in, .supply_good_in, .cmd_valid_in, .cmd_in, .cmd_addr_in, .cmd_data_in,
    .cmd_ready_out, .rsp_valid_out, .rsp_data_out, .rsp_id_out, .rsp_lock_out,
    .rsp_timeout_out, .busy_out, .flash_addr_out, .flash_ce_n_out, .flash_oe_n_out,
    .flash_we_n_out, .flash_dq_out, .flash_dq_oe_out, .flash_dq_in);

  flash_dev_model #(.MFR_CODE(MFR_CODE), .DEV_CODE(DEV_CODE)) dev (
    .mclk_in, .supply_in(supply_good_in), .ce_n_in(flash_ce_n_out), .oe_n_in(flash_oe_n_out),
    .we_n_in(flash_we_n_out), .addr_in(flash_addr_out), .dq_in(flash_dq_out), .dq_out(dev_dq));

  // ====================
  // helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  function automatic logic [15:0] lock_code(input logic lo, input logic hi);
    return {14'h0000, hi, lo};
  endfunction : lock_code

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask : chk

  // a command is held until the edge that takes it
  task automatic issue(input logic [2:0] c, input logic [18:0] ad, input logic [7:0] d);
    @(posedge mclk_in);
    cmd_valid_in <= 1'b1;
    cmd_in <= c;
    cmd_addr_in <= ad;
    cmd_data_in <= d;
    @(posedge mclk_in);
    for (int i = 0; cmd_ready_out !== 1'b1 && i < 5000; i++) @(posedge mclk_in);
    chk(cmd_ready_out, 1'b1);
    cmd_valid_in <= 1'b0;
  endtask : issue

  task automatic op(input logic [2:0] c, input logic [18:0] ad, input logic [7:0] d);
    if (c != CMD_LOAD) issue(c, ad, d);
    @(posedge mclk_in);
    for (int i = 0; rsp_valid_out !== 1'b1 && i < 9000; i++) @(posedge mclk_in);
    chk(rsp_valid_out, 1'b1);
  endtask : op

  task automatic rd_chk(input logic [18:0] ad, input logic [7:0] e);
    op(CMD_READ, ad, 8'h00);
    chk(rsp_data_out, e);
  endtask : rd_chk

  // ====================
  // main sequence
  initial begin
    repeat (3) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (100) @(posedge mclk_in);
    chk(busy_out, 1'b1);
    supply_good_in <= 1'b1;
    repeat (30) @(posedge mclk_in);
    chk(cmd_ready_out, 1'b0);
    $display("test power done");
    r = xs();
    a = {2'b01, r[16:0]};
    d1 = r[24:17];
    r = xs();
    d2 = r[7:0];
    issue(CMD_LOAD, a, d1);
    issue(CMD_LOAD, a ^ 19'h00001, d2);
    op(CMD_LOAD, a, d2);
    chk(rsp_timeout_out, 1'b0);
    chk(rsp_data_out, d2);
    rd_chk(a, d1);
    rd_chk(a ^ 19'h00002, 8'hFF);
    op(CMD_ERASE, 19'h00000, 8'h00);
    rd_chk(a, 8'hFF);
    $display("test program done");
    op(CMD_QUERY, 19'h00000, 8'h00);
    chk(rsp_id_out, {MFR_CODE, DEV_CODE});
    chk(rsp_lock_out, lock_code(1'b0, 1'b0));
    r = xs();
    b = {5'h00, r[13:0]};
    op(CMD_LOCK, b, 8'h00);
    op(CMD_QUERY, 19'h00000, 8'h00);
    chk(rsp_lock_out, lock_code(1'b1, 1'b0));
    chk(rsp_data_out, 8'hFF);
    issue(CMD_LOAD, b, d1 & 8'hFE);
    op(CMD_LOAD, b, 8'h00);
    rd_chk(b, 8'hFF);
    issue(CMD_LOAD, a, d2);
    op(CMD_LOAD, a, d2);
    rd_chk(a, d2);
    op(CMD_ERASE, 19'h00000, 8'h00);
    rd_chk(a, d2);
    $display("test lockout done");
    supply_good_in <= 1'b0;
    repeat (5) @(posedge mclk_in);
    chk(cmd_ready_out, 1'b0);
    chk(busy_out, 1'b1);
    $display("test supply drop done");
    stop_test();
  end

  // hang guard, well beyond the longest sequence of polls
  initial begin
    #400000;
    miscompares++;
    stop_test();
  end
endmodule : tb_top
